/* logic/codec_err_pkg.sv */
package codec_err_pkg;
    // apb map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_NOTIFY = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_INT_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h00C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;

    // event bit positions in notify and mask; adc then dac follow
    localparam int EV_TEST = 0;
    localparam int EV_SERIAL = 1;
    localparam int EV_CLOCK = 2;
    localparam int EV_ADC_LSB = 3;

    // interrupt control fields
    localparam int INTCFG_POL_BIT = 0;
    localparam int INTCFG_PP_BIT = 1;
    localparam logic [1:0] INTCFG_RST = 2'h0;

    // config fields
    localparam int CFG_PDN_LSB = 0;
    localparam int CFG_SPEED_LSB = 16;
    localparam logic [1:0] SPEED_RST = 2'h0;

    // status fields
    localparam int STAT_MUTE_BIT = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
endpackage

/* logic/sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* logic/codec_error_interrupt_unit.sv */
// Contract
// R1: notify bits set on rising edge of an error, not on its level.
// R2: a set notify bit stays 1 until the notify register is cleared.
// R3: test-mode entry flagged; no mute and no power-down cycle needed.
// R4: word or bit clock invalid flags serial error and mutes outputs.
// R5: speed class mismatch or pll unlock flags clocking error and mutes.
// R6: per-channel adc overflow flagged; operation continues unmuted.
// R7: per-channel dac clip flagged; operation continues unmuted.
// R8: any unmasked notified error drives the interrupt pin active.
// R9: notify bits record every error whatever the mask says.
// R10: mask bits only gate the interrupt pin, nothing else.
// R11: interrupt active level follows the two-bit pin config field; the code takes the level from its polarity bit (bit 0) only.
// R12: pin offers open-drain and push-pull; shared lines use open-drain.
// R13: reading notify sets the mask bit of each reported error.
// R14: controller clears mask bits after fixing the error.
// R15: reset returns masks, pin config and notify bits to defaults.
// R16: reading notify clears the bits it reported.
// R17: open-drain releases the pin when idle; push-pull drives idle level.
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
module codec_error_interrupt_unit
    import codec_err_pkg::*;
#(
    parameter int N_ADC = 4,
    parameter int N_DAC = 5,
    parameter int N_PDN = 9
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // error sources, asynchronous
    input wire logic test_mode_i,
    input wire logic fs_invalid_i,
    input wire logic sclk_invalid_i,
    input wire logic [1:0] speed_class_i,
    input wire logic pll_locked_i,
    input wire logic [N_ADC-1:0] adc_overflow_i,
    input wire logic [N_DAC-1:0] dac_clip_i,
    // converter control
    output logic mute_o,
    output logic [N_PDN-1:0] converter_powerdown_bits_o,
    // interrupt
    output logic irq_o,
    output logic int_pin_o,
    output logic int_pin_oe_o
);
    localparam int EVT_W = EV_ADC_LSB + N_ADC + N_DAC;
    localparam int EV_DAC_LSB = EV_ADC_LSB + N_ADC;
    localparam int RAW_W = 6 + N_ADC + N_DAC;
    localparam logic [EVT_W-1:0] MASK_RST = '0;
    localparam logic [N_PDN-1:0] PDN_RST = '1;

    if (N_ADC < 1 || N_DAC < 1 || EVT_W > 32 || N_PDN < 1 ||
        N_PDN > CFG_SPEED_LSB) begin : g_bad_param
        $error("codec_error_interrupt_unit: unsupported parameters");
    end

    typedef struct packed {
        logic [EVT_W-1:0] prev;
        logic [EVT_W-1:0] notify;
        logic [EVT_W-1:0] mask;
        logic [1:0] int_cfg;
        logic [N_PDN-1:0] pdn;
        logic [1:0] speed_cfg;
        logic mute;
        logic pdn_armed;
        logic [31:0] rdata;
        logic irq;
        logic pin_out;
        logic pin_oe;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic rst_n;
    logic [RAW_W-1:0] raw;
    logic [RAW_W-1:0] raw_s;
    logic [EVT_W-1:0] evt_lvl;
    logic [EVT_W-1:0] rise;
    logic [EVT_W-1:0] rd_bits;
    logic rd_notify;
    logic wr_acc;
    logic setup;
    logic all_set;
    logic all_clr;
    logic err_rise;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = hit(a, ADDR_NOTIFY) | hit(a, ADDR_MASK) |
                 hit(a, ADDR_INT_CTRL) | hit(a, ADDR_CONFIG) |
                 hit(a, ADDR_STATUS);
    endfunction

    // reset release through two flops
    sync_2ff #(
        .W(1)
    ) u_rst_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(reset_n_i),
        .d_i(1'b1),
        .q_o(rst_n)
    );

    // unlock crosses as a high level: a flushed sync reads locked, no false edge
    assign raw = {dac_clip_i, adc_overflow_i, ~pll_locked_i, speed_class_i,
                  sclk_invalid_i, fs_invalid_i, test_mode_i};

    sync_2ff #(
        .W(RAW_W)
    ) u_evt_sync (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n),
        .d_i(raw),
        .q_o(raw_s)
    );

    // speed bits cross separately; a one-cycle skew may flag a change
    always_comb begin
        evt_lvl = '0;
        // R3: test mode level
        evt_lvl[EV_TEST] = raw_s[0];
        // R4: either serial clock invalid
        evt_lvl[EV_SERIAL] = raw_s[1] | raw_s[2];
        // R5: speed mismatch or unlock
        evt_lvl[EV_CLOCK] = (raw_s[4:3] != s_q.speed_cfg) | raw_s[5];
        // R6: adc overflow per channel
        evt_lvl[EV_ADC_LSB +: N_ADC] = raw_s[6 +: N_ADC];
        // R7: dac clip per channel
        evt_lvl[EV_DAC_LSB +: N_DAC] = raw_s[6 + N_ADC +: N_DAC];
    end

    // R1: edge, not level
    assign rise = evt_lvl & ~s_q.prev;
    assign rd_bits = s_q.rdata[EVT_W-1:0];
    assign setup = psel_i & ~penable_i;
    assign wr_acc = psel_i & penable_i & pwrite_i;
    assign rd_notify = psel_i & penable_i & ~pwrite_i &
                       hit(paddr_i, ADDR_NOTIFY);
    assign all_set = &s_q.pdn;
    assign all_clr = ~|s_q.pdn;
    assign err_rise = rise[EV_SERIAL] | rise[EV_CLOCK];

    always_comb begin
        s_d = s_q;
        s_d.prev = evt_lvl;
        // R16: clear only what the read reported, so a fresh edge survives
        // R2: otherwise a set bit holds
        // R9: set regardless of mask
        s_d.notify = (rd_notify ? (s_q.notify & ~rd_bits) : s_q.notify)
                     | rise;
        // R13: reported errors become masked
        if (rd_notify) begin
            s_d.mask = s_q.mask | rd_bits;
        end
        if (wr_acc && hit(paddr_i, ADDR_MASK)) begin
            s_d.mask = pwdata_i[EVT_W-1:0];
        end
        if (wr_acc && hit(paddr_i, ADDR_INT_CTRL)) begin
            s_d.int_cfg = pwdata_i[1:0];
        end
        if (wr_acc && hit(paddr_i, ADDR_CONFIG)) begin
            s_d.pdn = pwdata_i[CFG_PDN_LSB +: N_PDN];
            s_d.speed_cfg = pwdata_i[CFG_SPEED_LSB +: 2];
        end
        // R4: recovery needs all power-down bits set, then all cleared
        // R5: same recovery path
        if (s_q.mute && all_set) begin
            s_d.pdn_armed = 1'b1;
        end
        if (s_q.pdn_armed && all_clr) begin
            s_d.mute = 1'b0;
            s_d.pdn_armed = 1'b0;
        end
        // R4: a new error wins over recovery
        if (err_rise) begin
            s_d.mute = 1'b1;
            s_d.pdn_armed = 1'b0;
        end
        // R8: unmasked notify raises the line
        // R10: mask touches nothing else
        s_d.irq = |(s_d.notify & ~s_d.mask);
        // R11: active level from config
        s_d.pin_out = s_d.irq ? s_d.int_cfg[INTCFG_POL_BIT]
                              : ~s_d.int_cfg[INTCFG_POL_BIT];
        // R12: drive mode select
        // R17: open-drain releases when idle
        s_d.pin_oe = s_d.int_cfg[INTCFG_PP_BIT] | s_d.irq;
        // read data latched in setup so the access edge sees a stable word
        if (setup) begin
            s_d.rdata = '0;
            if (hit(paddr_i, ADDR_NOTIFY)) begin
                s_d.rdata[EVT_W-1:0] = s_q.notify;
            end
            if (hit(paddr_i, ADDR_MASK)) begin
                s_d.rdata[EVT_W-1:0] = s_q.mask;
            end
            if (hit(paddr_i, ADDR_INT_CTRL)) begin
                s_d.rdata[1:0] = s_q.int_cfg;
            end
            if (hit(paddr_i, ADDR_CONFIG)) begin
                s_d.rdata[CFG_PDN_LSB +: N_PDN] = s_q.pdn;
                s_d.rdata[CFG_SPEED_LSB +: 2] = s_q.speed_cfg;
            end
            if (hit(paddr_i, ADDR_STATUS)) begin
                s_d.rdata[STAT_MUTE_BIT] = s_q.mute;
                s_d.rdata[STAT_ARMED_BIT] = s_q.pdn_armed;
                s_d.rdata[STAT_LOCK_BIT] = ~raw_s[5];
            end
        end
    end

    // R15: every field back to default
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s_q.prev <= '0;
            s_q.notify <= '0;
            s_q.mask <= MASK_RST;
            s_q.int_cfg <= INTCFG_RST;
            s_q.pdn <= PDN_RST;
            s_q.speed_cfg <= SPEED_RST;
            s_q.mute <= 1'b0;
            s_q.pdn_armed <= 1'b0;
            s_q.rdata <= '0;
            s_q.irq <= 1'b0;
            s_q.pin_out <= 1'b1;
            s_q.pin_oe <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // zero-wait slave
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped(paddr_i);
    assign prdata_o = s_q.rdata;
    assign mute_o = s_q.mute;
    assign converter_powerdown_bits_o = s_q.pdn;
    assign irq_o = s_q.irq;
    assign int_pin_o = s_q.pin_out;
    assign int_pin_oe_o = s_q.pin_oe;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_pdn_set;
        s_q.mute && all_set && !err_rise;
    endsequence

    sequence s_pdn_clr;
        s_q.pdn_armed && all_clr && !err_rise;
    endsequence

    a_notify_edge_set: assert property ( // R1 R9
        (|rise) |=> ((s_q.notify & $past(rise)) == $past(rise)))
        else $error("notify bit missed an error edge");

    a_notify_hold: assert property ( // R2
        !rd_notify |=> ((s_q.notify & $past(s_q.notify))
                        == $past(s_q.notify)))
        else $error("notify bit dropped without a read");

    a_read_clear: assert property ( // R16
        (rd_notify && !(|rise)) |=> ((s_q.notify & $past(rd_bits)) == '0))
        else $error("notify read did not clear reported bits");

    a_read_auto_mask: assert property ( // R13
        rd_notify |=> ((s_q.mask & $past(rd_bits)) == $past(rd_bits)))
        else $error("notify read did not set mask bits");

    a_irq_unmasked: assert property ( // R8 R10
        ##1 (s_q.irq == |(s_q.notify & ~s_q.mask)))
        else $error("irq does not match unmasked notify");

    a_pin_active_level: assert property ( // R11
        s_q.irq |-> (s_q.pin_oe && s_q.pin_out == s_q.int_cfg[INTCFG_POL_BIT]))
        else $error("interrupt pin not at configured active level");

    a_pin_idle_drive: assert property ( // R12 R17
        !s_q.irq |-> (s_q.pin_oe == s_q.int_cfg[INTCFG_PP_BIT]))
        else $error("interrupt pin idle drive wrong");

    a_mute_on_error: assert property ( // R4 R5
        err_rise |=> (s_q.mute && !s_q.pdn_armed))
        else $error("serial or clocking error did not mute");

    a_soft_no_mute: assert property ( // R3 R6 R7
        (!s_q.mute && !err_rise) |=> !s_q.mute)
        else $error("mute raised without a muting error");

    a_recover_arm: assert property ( // R4 R5
        s_pdn_set |=> s_q.pdn_armed)
        else $error("recovery not armed by power-down bits");

    a_mute_recover: assert property ( // R4 R5
        s_pdn_clr |=> !s_q.mute)
        else $error("mute not released after power-down cycle");

    a_mute_stays: assert property ( // R4 R5
        (s_q.mute && !s_q.pdn_armed) |=> s_q.mute)
        else $error("mute released without power-down cycle");

    a_reset_default: assert property ( // R15
        $rose(rst_n) |-> (s_q.notify == '0 && s_q.mask == MASK_RST &&
                          s_q.int_cfg == INTCFG_RST && !s_q.irq))
        else $error("registers not at defaults after reset");
endmodule

/* verification/int_line_model.sv */
`timescale 1ns/1ps
module int_line_model (
    // pin drive from the device
    input wire logic drive_i,
    input wire logic oe_i,
    // resolved net seen by the controller
    output wire logic line_o
);
    // pull-up on shared net
    // released pin floats up; never leave the last driven value on the net
    assign line_o = oe_i ? drive_i : 1'b1;
endmodule

/* verification/tb_codec_error_interrupt_unit.sv */
`timescale 1ns/1ps
module tb_codec_error_interrupt_unit;
    import codec_err_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, test_mode;
    logic fs_inv, sclk_inv, pll_locked, mute, irq, pin, oe, line;
    logic [1:0] speed;
    logic [3:0] adc_ov;
    logic [4:0] dac_clip;
    logic [8:0] pdn;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic er;
    int fails = 0;
    int cmp_count = 0;

    codec_error_interrupt_unit u_codec_error_interrupt_unit (
        .clk_sys_i(clk), .reset_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .test_mode_i(test_mode),
        .fs_invalid_i(fs_inv), .sclk_invalid_i(sclk_inv),
        .speed_class_i(speed), .pll_locked_i(pll_locked),
        .adc_overflow_i(adc_ov), .dac_clip_i(dac_clip), .mute_o(mute),
        .converter_powerdown_bits_o(pdn), .irq_o(irq), .int_pin_o(pin),
        .int_pin_oe_o(oe));
    int_line_model u_int_line_model (.drive_i(pin), .oe_i(oe),
        .line_o(line));

    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic settle;
        repeat (4) @(posedge clk);
    endtask

    task automatic recover;
        // all powerdown bits set then cleared
        apb(1'b1, ADDR_CONFIG, 32'h1FF);
        apb(1'b1, ADDR_CONFIG, 32'h0);
        settle();
        chk1(mute, 1'b0);
        chk({23'h0, pdn}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h0);
    endtask

    task automatic t_reset;
        rd_chk(ADDR_MASK, 32'h0);
        rd_chk(ADDR_INT_CTRL, 32'h0);
        rd_chk(ADDR_CONFIG, 32'h1FF);
        rd_chk(ADDR_NOTIFY, 32'h0);
        chk1(irq, 1'b0);
        chk1(oe, 1'b0);
        chk1(line, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_serial;
        fs_inv <= 1'b1;
        settle();
        chk1(irq, 1'b1);
        chk1(mute, 1'b1);
        chk1(line, 1'b0);
        fs_inv <= 1'b0;
        settle();
        chk1(irq, 1'b1);
        rd_chk(ADDR_NOTIFY, 32'h2);
        repeat (2) @(posedge clk);
        chk1(irq, 1'b0);
        rd_chk(ADDR_MASK, 32'h2);
        rd_chk(ADDR_NOTIFY, 32'h0);
        chk1(mute, 1'b1);
        recover();
        $display("test serial done");
    endtask

    task automatic t_clock;
        pll_locked <= 1'b0;
        settle();
        chk1(mute, 1'b1);
        pll_locked <= 1'b1;
        rd_chk(ADDR_NOTIFY, 32'h4);
        recover();
        $display("test clocking done");
    endtask

    task automatic t_speed;
        speed <= 2'h1;
        settle();
        chk1(mute, 1'b1);
        rd_chk(ADDR_STATUS, 32'h5);
        speed <= 2'h0;
        rd_chk(ADDR_NOTIFY, 32'h4);
        recover();
        sclk_inv <= 1'b1;
        settle();
        chk1(mute, 1'b1);
        sclk_inv <= 1'b0;
        rd_chk(ADDR_NOTIFY, 32'h2);
        recover();
        $display("test speed and bit clock done");
    endtask

    task automatic t_test_mode;
        test_mode <= 1'b1;
        settle();
        chk1(irq, 1'b1);
        chk1(mute, 1'b0);
        test_mode <= 1'b0;
        rd_chk(ADDR_NOTIFY, 32'h1);
        apb(1'b1, ADDR_MASK, 32'h0);
        $display("test mode entry done");
    endtask

    task automatic t_masked;
        apb(1'b1, ADDR_MASK, 32'hFFF);
        adc_ov <= 4'h4;
        settle();
        chk1(irq, 1'b0);
        chk1(mute, 1'b0);
        rd_chk(ADDR_NOTIFY, 32'h20);
        settle();
        rd_chk(ADDR_NOTIFY, 32'h0);
        adc_ov <= 4'h0;
        apb(1'b1, ADDR_MASK, 32'h0);
        $display("test masked done");
    endtask

    task automatic t_pin_modes;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_INT_CTRL, 32'(m));
            settle();
            chk1(line, m[1] ? ~m[0] : 1'b1);
            chk1(oe, m[1]);
            dac_clip <= 5'h1 << m;
            settle();
            chk1(line, m[0]);
            chk1(mute, 1'b0);
            dac_clip <= 5'h0;
            rd_chk(ADDR_NOTIFY, 32'h80 << m);
            apb(1'b1, ADDR_MASK, 32'h0);
        end
        apb(1'b1, ADDR_INT_CTRL, 32'h0);
        $display("test pin modes done");
    endtask

    task automatic t_unmapped;
        apb(1'b1, 12'h020, 32'hFFFF);
        chk1(er, 1'b1);
        rd_chk(12'h020, 32'h0);
        chk1(er, 1'b1);
        $display("test unmapped done");
    endtask

    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        {rst_n, psel, penable, pwrite, test_mode, fs_inv, sclk_inv} = '0;
        {speed, adc_ov, dac_clip, paddr, pwdata} = '0;
        pll_locked = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_serial();
        t_clock();
        t_speed();
        t_test_mode();
        t_masked();
        t_pin_modes();
        t_unmapped();
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule
